//--- core/sioe_top.sv
// Serial I/O expander: 16-bit shift frame to parallel pins
// What this block does
// R1: Clear low: output high, regs reset, pins released
// R2: Select low without clocks fixes open-drain config
// R3: Select low in mode 1 starts frame
// R4: First fall puts pin 0 live on output
// R5: Same first fall captures remaining fifteen pins
// R6: Each later fall shifts next sampled bit
// R7: Serial input sampled each rise, bit 0 first
// R8: Mode 1 frame end loads direction/type register
// R9: Data mode frames run same shift sequence
// R10: Frame end updates all pins together
// R11: After init, frames load only level register
// R12: Pins hold state during a frame
// R13: Mode 0 open-drain; mode 1 per-bit config
// R14: Frame: sixteen or more rises load last sixteen bits; no serial_in to serial_out path
// R15: Pin behaviour follows type and level pair
// R16: No-clock select-low means mode 0
// R17: Short frames update nothing
module sioe_top
  import sioe_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clear_in_n,
  input  wire logic        select_n,
  input  wire logic        shift_clk,
  input  wire logic        serial_in,
  output logic             serial_out,
  input  wire logic [15:0] expander_pins_in,
  output logic      [15:0] expander_pins_out,
  output logic      [15:0] expander_pins_oe,
  output logic             init_done
);
  typedef enum logic [1:0] {SIOE_INIT, SIOE_DATA} sioe_mode_t;

  typedef struct packed {
    sioe_mode_t             mode;
    logic [15:0]            dir_type;
    logic [15:0]            level;
    logic [15:0]            shreg;
    logic [15:0]            samp;
    logic [SIOE_CNT_W-1:0]  rises;
    logic [SIOE_CNT_W-1:0]  falls;
    logic                   clk_seen;
    logic [SIOE_TMR_W-1:0]  low_tmr;
    logic                   sck_d;
    logic                   sel_d;
    logic                   sout;
    logic [15:0]            pout;
    logic [15:0]            poe;
    logic                   done;
  } sioe_state_t;

  sioe_state_t st;
  sioe_state_t next_st;

  logic        clr_s;
  logic        sel_s;
  logic        sck_s;
  logic        din_s;
  logic [15:0] pins_s;
  logic [15:0] samp_now;
  logic [15:0] new_out;
  logic [15:0] new_oe;
  logic        sck_rise;
  logic        sck_fall;
  logic        sel_rise;
  logic        frame_ok;

  sioe_sync u_sync_clr (.core_clk(core_clk), .rst_n(rst_n), .async_in(clear_in_n),
                        .sync_out(clr_s));
  sioe_sync u_sync_sel (.core_clk(core_clk), .rst_n(rst_n), .async_in(select_n),
                        .sync_out(sel_s));
  sioe_sync u_sync_sck (.core_clk(core_clk), .rst_n(rst_n), .async_in(shift_clk),
                        .sync_out(sck_s));
  sioe_sync u_sync_din (.core_clk(core_clk), .rst_n(rst_n), .async_in(serial_in),
                        .sync_out(din_s));

  genvar gi;
  generate
    for (gi = 0; gi < SIOE_NBITS; gi++) begin : g_pin
      sioe_sync u_sync_pin (.core_clk(core_clk), .rst_n(rst_n),
                            .async_in(expander_pins_in[gi]),
                            .sync_out(pins_s[gi]));
      // R15: pin pair decode
      sioe_pin u_pin (.dir_type(st.dir_type[gi]), .level(st.level[gi]),
                      .pin_in(pins_s[gi]), .pin_out(new_out[gi]),
                      .pin_oe(new_oe[gi]), .sample(samp_now[gi]));
    end
  endgenerate

  assign sck_rise = sck_s & ~st.sck_d;
  assign sck_fall = ~sck_s & st.sck_d;
  assign sel_rise = sel_s & ~st.sel_d;
  // R14: sixteen bits per frame
  // R17: full frame only
  assign frame_ok = (st.rises == SIOE_FRAME_EDGES);

  always_comb begin
    next_st       = st;
    next_st.sck_d = sck_s;
    next_st.sel_d = sel_s;
    if (!clr_s) begin
      // R1: clear holds defaults
      next_st          = '0;
      next_st.mode     = SIOE_INIT;
      next_st.dir_type = SIOE_DIR_RESET;
      next_st.level    = SIOE_LEVEL_RESET;
      next_st.sout     = 1'b1;
      next_st.pout     = SIOE_LEVEL_RESET;
      next_st.poe      = 16'h0000;
      next_st.sck_d    = sck_s;
      next_st.sel_d    = sel_s;
    end else if (!sel_s) begin
      // R3: select low opens frame
      // R9: same sequence in data mode
      if (st.mode == SIOE_INIT && !st.clk_seen && st.low_tmr != '1) begin
        next_st.low_tmr = st.low_tmr + 1'b1;
      end
      if (sck_fall) begin
        next_st.clk_seen = 1'b1;
        if (st.falls == '0) begin
          // R4: pin 0 live on first fall
          next_st.sout = samp_now[0];
          next_st.samp = samp_now;
        end else begin
          // R6: next sampled bit out
          next_st.sout = st.samp[st.falls[3:0]];
        end
        if (st.falls != SIOE_FRAME_EDGES) begin
          next_st.falls = st.falls + 1'b1;
        end
      end
      if (sck_rise) begin
        next_st.clk_seen = 1'b1;
        // R5: rest captured at first fall, not at rise
        // R7: serial input, bit 0 first
        next_st.shreg = {din_s, st.shreg[15:1]};
        if (st.rises != SIOE_FRAME_EDGES) begin
          next_st.rises = st.rises + 1'b1;
        end
      end
    end else begin
      if (sel_rise) begin
        if (st.mode == SIOE_INIT) begin
          if (!st.clk_seen && st.low_tmr >= SIOE_TMR_W'(SELECT_LOW_MIN_CYC)) begin
            // R16: no clocks, so mode 0
            // R2: direction stays zero
            // R13: all open-drain
            next_st.dir_type = SIOE_DIR_RESET;
            next_st.mode     = SIOE_DATA;
            next_st.done     = 1'b1;
          end else if (frame_ok) begin
            // R8: load direction/type
            next_st.dir_type = st.shreg;
            next_st.mode     = SIOE_DATA;
            next_st.done     = 1'b1;
          end
        end else if (frame_ok) begin
          // R11: data frames load level only
          next_st.level = st.shreg;
        end
      end
      next_st.rises    = '0;
      next_st.falls    = '0;
      next_st.clk_seen = 1'b0;
      next_st.low_tmr  = '0;
      // R12: pins change only here and on clear
      // R10: all pins together
      next_st.pout = new_out;
      next_st.poe  = new_oe;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st          <= '0;
      st.mode     <= SIOE_INIT;
      st.dir_type <= SIOE_DIR_RESET;
      st.level    <= SIOE_LEVEL_RESET;
      st.sout     <= 1'b1;
      st.pout     <= SIOE_LEVEL_RESET;
      st.sck_d    <= 1'b1;
      st.sel_d    <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign serial_out        = st.sout;
  assign expander_pins_out = st.pout;
  assign expander_pins_oe  = st.poe;
  assign init_done         = st.done;

  property p_clear_out;
    @(posedge core_clk) disable iff (!rst_n)
      !clr_s |=> serial_out && expander_pins_oe == 16'h0000;
  endproperty
  a_clear_out: assert property (p_clear_out) else $error("clear not honoured"); // R1

  property p_short_frame;
    @(posedge core_clk) disable iff (!rst_n)
      (clr_s && sel_rise && st.mode == SIOE_DATA && !frame_ok) |=> $stable(st.level);
  endproperty
  a_short_frame: assert property (p_short_frame) else $error("short frame updated"); // R17

  property p_pins_hold;
    @(posedge core_clk) disable iff (!rst_n)
      (clr_s && !sel_s) |=> $stable(expander_pins_out) && $stable(expander_pins_oe);
  endproperty
  a_pins_hold: assert property (p_pins_hold) else $error("pins moved in frame"); // R12

  property p_data_level;
    @(posedge core_clk) disable iff (!rst_n)
      (clr_s && sel_rise && st.mode == SIOE_DATA && frame_ok)
        |=> st.level == $past(st.shreg) && $stable(st.dir_type);
  endproperty
  a_data_level: assert property (p_data_level) else $error("data frame misloaded"); // R11

  property p_mode1_load;
    @(posedge core_clk) disable iff (!rst_n)
      (clr_s && sel_rise && st.mode == SIOE_INIT && st.clk_seen && frame_ok)
        |=> st.dir_type == $past(st.shreg) && init_done;
  endproperty
  a_mode1_load: assert property (p_mode1_load) else $error("config not loaded"); // R8

  property p_mode0;
    @(posedge core_clk) disable iff (!rst_n)
      (clr_s && sel_rise && st.mode == SIOE_INIT && !st.clk_seen
       && st.low_tmr >= SIOE_TMR_W'(SELECT_LOW_MIN_CYC))
        |=> st.dir_type == 16'h0000 && init_done;
  endproperty
  a_mode0: assert property (p_mode0) else $error("mode 0 failed"); // R2

  sequence s_first_fall;
    clr_s && !sel_s && sck_fall && st.falls == 5'h00;
  endsequence
  property p_first_bit;
    @(posedge core_clk) disable iff (!rst_n)
      s_first_fall |=> serial_out == $past(pins_s[0] | ~(~st.dir_type[0] & st.level[0]));
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("first bit wrong"); // R4

  property p_shift_in;
    @(posedge core_clk) disable iff (!rst_n)
      (clr_s && !sel_s && sck_rise) |=> st.shreg[15] == $past(din_s);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("serial input lost"); // R7

  property p_pin_apply;
    @(posedge core_clk) disable iff (!rst_n)
      (clr_s && sel_s) |=> expander_pins_oe == $past(new_oe);
  endproperty
  a_pin_apply: assert property (p_pin_apply) else $error("pins not applied"); // R10

  property p_clear_regs;
    @(posedge core_clk) disable iff (!rst_n)
      !clr_s |=> st.dir_type == SIOE_DIR_RESET && st.level == SIOE_LEVEL_RESET
                 && st.mode == SIOE_INIT && !init_done;
  endproperty
  a_clear_regs: assert property (p_clear_regs) else $error("clear left registers set"); // R1

  property p_sample_view;
    @(posedge core_clk) disable iff (!rst_n)
      samp_now == ((~st.dir_type & st.level & pins_s)
                   | ~(~st.dir_type & st.level));
  endproperty
  a_sample_view: assert property (p_sample_view) else $error("disabled input not high"); // R15

  property p_pin_drive;
    @(posedge core_clk) disable iff (!rst_n)
      (clr_s && sel_s) |=> expander_pins_oe == ($past(st.dir_type) | ~$past(st.level))
        && (expander_pins_out & expander_pins_oe) == ($past(st.level) & expander_pins_oe);
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin pair decode wrong"); // R15

  property p_init_short;
    @(posedge core_clk) disable iff (!rst_n)
      (clr_s && sel_rise && st.mode == SIOE_INIT && st.clk_seen && !frame_ok)
        |=> st.mode == SIOE_INIT && !init_done && $stable(st.dir_type);
  endproperty
  a_init_short: assert property (p_init_short) else $error("short config frame used"); // R17

  sequence s_sel_fall;
    clr_s && !sel_s && st.sel_d;
  endsequence
  property p_frame_start;
    @(posedge core_clk) disable iff (!rst_n)
      s_sel_fall |-> st.rises == 5'h00 && st.falls == 5'h00 && !st.clk_seen;
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame not prepared"); // R3

  property p_dir_fixed;
    @(posedge core_clk) disable iff (!rst_n)
      (clr_s && st.mode == SIOE_DATA) |=> $stable(st.dir_type);
  endproperty
  a_dir_fixed: assert property (p_dir_fixed) else $error("config moved in data mode"); // R11

  sequence s_later_fall;
    clr_s && !sel_s && sck_fall && st.falls != 5'h00 && st.falls != 5'h10;
  endsequence
  property p_later_bit;
    @(posedge core_clk) disable iff (!rst_n)
      s_later_fall |=> serial_out == $past(st.samp[st.falls[3:0]]);
  endproperty
  a_later_bit: assert property (p_later_bit) else $error("serial order wrong"); // R6
endmodule

//--- core/sioe_pkg.sv
// Shared constants for the serial I/O expander
package sioe_pkg;
  localparam int          SIOE_NBITS        = 16;
  localparam int          SIOE_CNT_W        = 5;
  localparam logic [4:0]  SIOE_FRAME_EDGES  = 5'h10;
  localparam logic [15:0] SIOE_DIR_RESET    = 16'h0000;
  localparam logic [15:0] SIOE_LEVEL_RESET  = 16'hFFFF;
  localparam int          SIOE_CLK_NS       = 100;
  localparam int          SELECT_LOW_MIN_NS = 1000;
  localparam int          SELECT_LOW_MIN_CYC =
    (SELECT_LOW_MIN_NS + SIOE_CLK_NS - 1) / SIOE_CLK_NS;
  localparam int          SIOE_TMR_W        = 8;
endpackage

//--- core/sioe_sync.sv
// Two-flop synchroniser for one level
module sioe_sync
  import sioe_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      sync_out
);
  typedef struct packed {
    logic s1;
    logic s2;
  } sioe_sync_t;
  sioe_sync_t st;
  sioe_sync_t next_st;
  always_comb begin
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= 2'b11;
    end else begin
      st <= next_st;
    end
  end
  assign sync_out = st.s2;
endmodule

//--- core/sioe_pin.sv
// One expander pin: drive, enable and input view
module sioe_pin
  import sioe_pkg::*;
(
  input  wire logic dir_type,
  input  wire logic level,
  input  wire logic pin_in,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      sample
);
  always_comb begin
    pin_out = level;
    pin_oe  = dir_type | ~level;
    sample  = (!dir_type && level) ? pin_in : 1'b1;
  end
endmodule

//--- bench/sioe_mcu.sv
// Controller model that drives the expander's serial side
module sioe_mcu
  import sioe_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic serial_out,
  output logic      select_n,
  output logic      shift_clk,
  output logic      serial_in
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    select_n  = 1'b1;
    shift_clk = 1'b1;
    serial_in = 1'b0;
  end

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Frame of nrise clocks; shift clock idles high
  task automatic frame(input logic [15:0] wr, input int nrise, output logic [15:0] rd);
    rd = 16'hFFFF;
    step(1);
    select_n = 1'b0;
    step(4);
    for (int k = 0; k < nrise; k++) begin
      // bit 0 first, sampled at rise
      shift_clk = 1'b0;
      serial_in = wr[k];
      step(4);
      shift_clk = 1'b1;
      step(3);
      rd[k] = serial_out;
      step(1);
    end
    step(3);
    select_n  = 1'b1;
    serial_in = ~serial_in;
  endtask

  task automatic hold_low(input int n);
    step(1);
    select_n = 1'b0;
    step(n);
    select_n = 1'b1;
  endtask
endmodule

//--- bench/sioe_top_tb_top.sv
// Testbench for the serial I/O expander
`define CHK(nm, exp, got) begin checks++; if ((exp) !== (got)) begin err_count++; \
  $display("CHECK FAILED %s exp=%h got=%h", nm, exp, got); end end
module sioe_top_tb_top
  import sioe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        core_clk = 1'b0;
  logic        rst_n;
  logic        clear_in_n;
  logic        select_n;
  logic        shift_clk;
  logic        serial_in;
  logic        serial_out;
  logic [15:0] pins_in;
  logic [15:0] pins_out;
  logic [15:0] pins_oe;
  logic        init_done;
  logic [15:0] ext;
  logic [15:0] dir;
  logic [15:0] lvl;
  int          err_count = 0;
  int          checks = 0;

  always #50 core_clk = ~core_clk;

  // Pin wire: driven value where enabled, else external level
  assign pins_in = (pins_oe & pins_out) | (~pins_oe & ext);

  sioe_top dut_u (
    .core_clk          (core_clk),
    .rst_n             (rst_n),
    .clear_in_n        (clear_in_n),
    .select_n          (select_n),
    .shift_clk         (shift_clk),
    .serial_in         (serial_in),
    .serial_out        (serial_out),
    .expander_pins_in  (pins_in),
    .expander_pins_out (pins_out),
    .expander_pins_oe  (pins_oe),
    .init_done         (init_done)
  );

  sioe_mcu mcu_u (
    .core_clk   (core_clk),
    .serial_out (serial_out),
    .select_n   (select_n),
    .shift_clk  (shift_clk),
    .serial_in  (serial_in)
  );

  task automatic close_out();
    $display("errors=%0d checks=%0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check_reset();
    `CHK("serial_out", 1'b1, serial_out)
    `CHK("pins_oe", 16'h0000, pins_oe)
    `CHK("pins_out", SIOE_LEVEL_RESET, pins_out)
    `CHK("init_done", 1'b0, init_done)
  endtask

  task automatic check_pins();
    `CHK("pins_oe", dir | ~lvl, pins_oe)
    `CHK("pins_out", lvl & (dir | ~lvl), pins_out & pins_oe)
  endtask

  task automatic data_frame(input logic [15:0] wr, input int nrise);
    logic [15:0] rd;
    logic [15:0] poe;
    logic [15:0] pout;
    poe  = pins_oe;
    pout = pins_out;
    mcu_u.frame(wr, nrise, rd);
    `CHK("pins_oe_hold", poe, pins_oe)
    `CHK("pins_out_hold", pout, pins_out)
    if (nrise == 16) begin
      `CHK("read_word", (ext & ~dir & lvl) | ~(~dir & lvl), rd)
      lvl = wr;
    end
    mcu_u.step(6);
    `CHK("init_done", 1'b1, init_done)
    check_pins();
  endtask

  task automatic t_mode1();
    logic [15:0] rd;
    ext = 16'hA5C3;
    mcu_u.frame(16'h0FF0, 16, rd);
    `CHK("cfg_read", ext, rd)
    `CHK("pins_oe_hold", 16'h0000, pins_oe)
    mcu_u.step(6);
    dir = 16'h0FF0;
    `CHK("init_done", 1'b1, init_done)
    check_pins();
  endtask

  task automatic t_mode0();
    logic [15:0] rd;
    clear_in_n = 1'b0;
    mcu_u.step(4);
    check_reset();
    clear_in_n = 1'b1;
    mcu_u.step(5);
    mcu_u.frame(16'h1234, 8, rd);
    `CHK("short_cfg_read", ext[7:0], rd[7:0])
    mcu_u.step(6);
    `CHK("init_short", 1'b0, init_done)
    `CHK("pins_oe_init", 16'h0000, pins_oe)
    mcu_u.hold_low(SELECT_LOW_MIN_CYC + 2);
    mcu_u.step(6);
    dir = SIOE_DIR_RESET;
    lvl = SIOE_LEVEL_RESET;
    `CHK("init_done", 1'b1, init_done)
    `CHK("pins_oe", 16'h0000, pins_oe)
    data_frame(16'h00FE, 16);
    data_frame(16'h00FF, 16);
  endtask

  initial begin
    rst_n      = 1'b0;
    clear_in_n = 1'b1;
    ext        = 16'hFFFF;
    dir        = SIOE_DIR_RESET;
    lvl        = SIOE_LEVEL_RESET;
    repeat (12) @(posedge core_clk);
    #1;
    check_reset();
    rst_n = 1'b1;
    mcu_u.step(6);
    t_mode1();
    data_frame(16'h0F0F, 16);
    data_frame(16'h0000, 8);
    ext = 16'h5A3C;
    data_frame(16'hF0A5, 16);
    t_mode0();
    close_out();
  end

  initial begin
    #1_000_000;
    err_count++;
    close_out();
  end
endmodule
